// ---- hw/csr_pkg.sv ----
// Package for the CPU status, register file and stack block
package csr_pkg;
    // ****************************************************************
    // Status flag bit positions
    // ****************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ****************************************************************
    // I/O register addresses and reset values
    // ****************************************************************
    localparam logic [5:0] IO_STATUS_FLAGS   = 6'h3f;
    localparam logic [5:0] IO_STACK_PTR_HIGH = 6'h3e;
    localparam logic [5:0] IO_STACK_PTR_LOW  = 6'h3d;
    localparam logic [5:0] IO_PROGRAM_PAGE   = 6'h3b;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [15:0] STACK_RESET      = 16'h0000;
    localparam logic       PAGE_RESET        = 1'b0;
    localparam int         PAGE_BIT          = 0;

    // ****************************************************************
    // Register file layout
    // ****************************************************************
    localparam int REG_COUNT = 32;
    localparam logic [4:0] PTR_X_LOW = 5'h1a;
    localparam logic [4:0] PTR_Y_LOW = 5'h1c;
    localparam logic [4:0] PTR_Z_LOW = 5'h1e;

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    typedef enum logic [3:0] {
        ALU_ADD = 4'h0,
        ALU_ADC = 4'h1,
        ALU_SUB = 4'h2,
        ALU_SBC = 4'h3,
        ALU_AND = 4'h4,
        ALU_OR  = 4'h5,
        ALU_XOR = 4'h6,
        ALU_MOV = 4'h7,
        ALU_INC = 4'h8,
        ALU_DEC = 4'h9
    } csr_alu_op_t;

    typedef enum logic [2:0] {
        STK_NONE     = 3'h0,
        STK_PUSH     = 3'h1,
        STK_CALL     = 3'h2,
        STK_POP      = 3'h3,
        STK_SUB_EXIT = 3'h4,
        STK_INT_EXIT = 3'h5
    } csr_stack_op_t;

    typedef enum logic [1:0] {
        PTR_PLAIN   = 2'h0,
        PTR_POSTINC = 2'h1,
        PTR_PREDEC  = 2'h2,
        PTR_DISP    = 2'h3
    } csr_ptr_mode_t;

    typedef enum logic [1:0] {
        TBL_NONE  = 2'h0,
        TBL_PLAIN = 2'h1,
        TBL_EXT   = 2'h2,
        TBL_STORE = 2'h3
    } csr_table_op_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic          valid;
        csr_alu_op_t   op;
        logic [4:0]    dst;
        logic [4:0]    src;
        logic          use_imm;
        logic [7:0]    imm;
    } csr_alu_req_t;

    typedef struct packed {
        logic          valid;
        logic [1:0]    sel;
        csr_ptr_mode_t mode;
        logic [5:0]    disp;
    } csr_ptr_req_t;

    typedef struct packed {
        logic          valid;
        logic [4:0]    reg_idx;
        logic [2:0]    bit_idx;
        logic          to_t;
    } csr_bit_req_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [5:0] addr;
        logic [7:0] wdata;
    } csr_io_req_t;
endpackage

// ---- hw/csr_core.sv ----
// CPU status flags, working registers, pointers, stack pointer and page select
// Operation
// - Arithmetic between registers or register and immediate completes in one cycle.
// - Status flags updated after every ALU operation except move.
// - Status flags never saved or restored on interrupt entry or exit.
// - Bit 7 global enable; zero blocks every interrupt.
// - Interrupt entry clears global enable; interrupt exit sets it.
// - Enable-set op sets, enable-clear op clears the global enable.
// - Bit 6 copy store; register bit to T and T to register bit.
// - Bit 5 records nibble half carry from arithmetic that defines it.
// - Bit 4 sign equals negative xor overflow after each flag-updating ALU operation; a software write can set any pattern.
// - Bit 3 overflow, 2 negative, 1 zero, 0 carry.
// - File supports 8/8, 2x8/8, 2x8/16 and 16/16 port schemes.
// - Working registers reachable as lowest 32 data-space addresses.
// - Six top registers pair into three 16-bit pointers.
// - Pointers support displacement, post-increment and pre-decrement.
// - Stack grows down; a data push decrements by one.
// - Return address push decrements stack pointer by two.
// - Pop, subroutine exit and interrupt exit each increment stack pointer by one.
// - Stack pointer is two readable, writable byte registers.
// - Unused page select bits read zero; software writes them zero.
// - Upper half page bit selects program half for extended read and store.
// - Plain table read ignores the page select.
`timescale 1ns/100ps
`default_nettype none
module csr_core
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    input  wire csr_pkg::csr_alu_req_t  i_alu,
    input  wire csr_pkg::csr_bit_req_t  i_bit,
    input  wire csr_pkg::csr_ptr_req_t  i_ptr,
    input  wire logic [4:0]             i_rd_a,
    input  wire logic [4:0]             i_rd_b,
    input  wire logic                   i_wr16_en,
    input  wire logic [4:0]             i_wr16_idx,
    input  wire logic [15:0]            i_wr16_data,
    input  wire logic                   i_dmem_we,
    input  wire logic [15:0]            i_dmem_wdata_addr,
    input  wire logic [7:0]             i_dmem_wdata,
    input  wire csr_pkg::csr_io_req_t   i_io,
    input  wire csr_pkg::csr_stack_op_t i_stack_op,
    input  wire logic                   i_irq_pending,
    input  wire logic                   i_irq_taken,
    input  wire logic                   i_irq_enable_set_op,
    input  wire logic                   i_irq_enable_clear_op,
    input  wire csr_pkg::csr_table_op_t i_table_op,
    output logic [7:0]                  o_rd_a,
    output logic [7:0]                  o_rd_b,
    output logic [15:0]                 o_rd16,
    output logic [7:0]                  o_io_rdata,
    output logic [7:0]                  o_status_flags,
    output logic [15:0]                 o_stack_ptr,
    output logic [15:0]                 o_ptr_addr,
    output logic                        o_ptr_is_reg,
    output logic                        o_irq_accept,
    output logic [16:0]                 o_prog_addr,
    output logic                        o_prog_valid
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]  regs [csr_pkg::REG_COUNT];
    logic [7:0]  status_flags;
    logic [15:0] stack_ptr;
    logic        upper_half_page_bit;

    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        unique case (sel)
            2'h0:    ptr_base = csr_pkg::PTR_X_LOW;
            2'h1:    ptr_base = csr_pkg::PTR_Y_LOW;
            default: ptr_base = csr_pkg::PTR_Z_LOW;
        endcase
    endfunction

    function automatic logic [15:0] pair16(input logic [4:0] lo);
        pair16 = {regs[lo | 5'h01], regs[lo & 5'h1e]};
    endfunction

    // ****************************************************************
    // ALU, single cycle combinational
    // ****************************************************************
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_r;
    logic [8:0] alu_w;
    logic       alu_h;
    logic       alu_v;
    logic       alu_arith;
    logic [7:0] next_status;

    always_comb
    begin
        alu_a     = regs[i_alu.dst];
        alu_b     = i_alu.use_imm ? i_alu.imm : regs[i_alu.src];
        alu_w     = 9'h000;
        alu_h     = status_flags[csr_pkg::FLAG_H];
        alu_v     = 1'b0;
        alu_arith = 1'b0;
        unique case (i_alu.op)
            csr_pkg::ALU_ADD, csr_pkg::ALU_ADC:
            begin
                alu_w = {1'b0, alu_a} + {1'b0, alu_b}
                      + {8'h00, (i_alu.op == csr_pkg::ALU_ADC) & status_flags[csr_pkg::FLAG_C]};
                alu_h = (alu_a[3] & alu_b[3]) | (alu_b[3] & ~alu_w[3]) | (~alu_w[3] & alu_a[3]);
                alu_v = (alu_a[7] & alu_b[7] & ~alu_w[7]) | (~alu_a[7] & ~alu_b[7] & alu_w[7]);
                alu_arith = 1'b1;
            end
            csr_pkg::ALU_SUB, csr_pkg::ALU_SBC:
            begin
                alu_w = {1'b0, alu_a} - {1'b0, alu_b}
                      - {8'h00, (i_alu.op == csr_pkg::ALU_SBC) & status_flags[csr_pkg::FLAG_C]};
                alu_h = (~alu_a[3] & alu_b[3]) | (alu_b[3] & alu_w[3]) | (alu_w[3] & ~alu_a[3]);
                alu_v = (alu_a[7] & ~alu_b[7] & ~alu_w[7]) | (~alu_a[7] & alu_b[7] & alu_w[7]);
                alu_arith = 1'b1;
            end
            csr_pkg::ALU_AND: alu_w = {status_flags[csr_pkg::FLAG_C], alu_a & alu_b};
            csr_pkg::ALU_OR:  alu_w = {status_flags[csr_pkg::FLAG_C], alu_a | alu_b};
            csr_pkg::ALU_XOR: alu_w = {status_flags[csr_pkg::FLAG_C], alu_a ^ alu_b};
            csr_pkg::ALU_MOV: alu_w = {status_flags[csr_pkg::FLAG_C], alu_b};
            csr_pkg::ALU_INC:
            begin
                alu_w = {status_flags[csr_pkg::FLAG_C], alu_a + 8'h01};
                alu_v = (alu_a == 8'h7f);
            end
            csr_pkg::ALU_DEC:
            begin
                alu_w = {status_flags[csr_pkg::FLAG_C], alu_a - 8'h01};
                alu_v = (alu_a == 8'h80);
            end
            default: alu_w = {status_flags[csr_pkg::FLAG_C], alu_a};
        endcase
        alu_r = alu_w[7:0];
        next_status = status_flags;
        if (i_alu.valid && i_alu.op != csr_pkg::ALU_MOV)
        begin
            next_status[csr_pkg::FLAG_C] = alu_w[8];
            next_status[csr_pkg::FLAG_Z] = (alu_r == 8'h00);
            next_status[csr_pkg::FLAG_N] = alu_r[7];
            next_status[csr_pkg::FLAG_V] = alu_v;
            next_status[csr_pkg::FLAG_S] = alu_r[7] ^ alu_v;
            if (alu_arith)
            begin
                next_status[csr_pkg::FLAG_H] = alu_h;
            end
        end
    end

    // ****************************************************************
    // Pointer address generation
    // ****************************************************************
    logic [4:0]  ptr_lo;
    logic [15:0] ptr_val;
    logic [15:0] ptr_eff;
    logic [15:0] ptr_new;

    always_comb
    begin
        ptr_lo  = ptr_base(i_ptr.sel);
        ptr_val = pair16(ptr_lo);
        ptr_eff = ptr_val;
        ptr_new = ptr_val;
        unique case (i_ptr.mode)
            csr_pkg::PTR_POSTINC: ptr_new = ptr_val + 16'h0001;
            csr_pkg::PTR_PREDEC:
            begin
                ptr_new = ptr_val - 16'h0001;
                ptr_eff = ptr_new;
            end
            csr_pkg::PTR_DISP: ptr_eff = ptr_val + {10'h000, i_ptr.disp};
            default: ptr_new = ptr_val;
        endcase
    end

    // ****************************************************************
    // Register file writes
    // ****************************************************************
    // Data-space store into the low 32 addresses lands on the file
    logic dmem_hits_reg;
    assign dmem_hits_reg = i_dmem_we && (i_dmem_wdata_addr[15:5] == 11'h000);

    generate
        for (genvar g = 0; g < csr_pkg::REG_COUNT; g++)
        begin : g_reg
            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                    regs[g] <= 8'h00;
                else if (i_wr16_en && (i_wr16_idx & 5'h1e) == 5'(g))
                    regs[g] <= i_wr16_data[7:0];
                else if (i_wr16_en && (i_wr16_idx | 5'h01) == 5'(g))
                    regs[g] <= i_wr16_data[15:8];
                else if (i_alu.valid && i_alu.dst == 5'(g))
                    regs[g] <= alu_r;
                else if (i_bit.valid && !i_bit.to_t && i_bit.reg_idx == 5'(g))
                    regs[g][i_bit.bit_idx] <= status_flags[csr_pkg::FLAG_T];
                else if (dmem_hits_reg && i_dmem_wdata_addr[4:0] == 5'(g))
                    regs[g] <= i_dmem_wdata;
                else if (i_ptr.valid && i_ptr.mode inside {csr_pkg::PTR_POSTINC,
                         csr_pkg::PTR_PREDEC})
                begin
                    if (ptr_lo == 5'(g))
                        regs[g] <= ptr_new[7:0];
                    else if ((ptr_lo | 5'h01) == 5'(g))
                        regs[g] <= ptr_new[15:8];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // Interrupt entry and exit never touch the arithmetic flags
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            status_flags <= csr_pkg::STATUS_RESET;
        else if (i_io.we && i_io.addr == csr_pkg::IO_STATUS_FLAGS)
            status_flags <= i_io.wdata;
        else
        begin
            status_flags <= next_status;
            if (i_bit.valid && i_bit.to_t)
                status_flags[csr_pkg::FLAG_T] <= regs[i_bit.reg_idx][i_bit.bit_idx];
            if (i_irq_taken || i_irq_enable_clear_op)
                status_flags[csr_pkg::FLAG_I] <= 1'b0;
            else if (i_stack_op == csr_pkg::STK_INT_EXIT || i_irq_enable_set_op)
                status_flags[csr_pkg::FLAG_I] <= 1'b1;
        end
    end

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            stack_ptr <= csr_pkg::STACK_RESET;
        else if (i_io.we && i_io.addr == csr_pkg::IO_STACK_PTR_HIGH)
            stack_ptr[15:8] <= i_io.wdata;
        else if (i_io.we && i_io.addr == csr_pkg::IO_STACK_PTR_LOW)
            stack_ptr[7:0] <= i_io.wdata;
        else
        begin
            unique case (i_stack_op)
                csr_pkg::STK_PUSH: stack_ptr <= stack_ptr - 16'h0001;
                csr_pkg::STK_CALL: stack_ptr <= stack_ptr - 16'h0002;
                csr_pkg::STK_POP, csr_pkg::STK_SUB_EXIT, csr_pkg::STK_INT_EXIT:
                    stack_ptr <= stack_ptr + 16'h0001;
                default: stack_ptr <= stack_ptr;
            endcase
        end
    end

    // ****************************************************************
    // Program page select
    // ****************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            upper_half_page_bit <= csr_pkg::PAGE_RESET;
        else if (i_io.we && i_io.addr == csr_pkg::IO_PROGRAM_PAGE)
            upper_half_page_bit <= i_io.wdata[csr_pkg::PAGE_BIT];
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_rd_a         <= 8'h00;
            o_rd_b         <= 8'h00;
            o_rd16         <= 16'h0000;
            o_io_rdata     <= 8'h00;
            o_status_flags <= csr_pkg::STATUS_RESET;
            o_stack_ptr    <= csr_pkg::STACK_RESET;
            o_ptr_addr     <= 16'h0000;
            o_ptr_is_reg   <= 1'b0;
            o_irq_accept   <= 1'b0;
            o_prog_addr    <= 17'h00000;
            o_prog_valid   <= 1'b0;
        end
        else
        begin
            o_rd_a         <= regs[i_rd_a];
            o_rd_b         <= regs[i_rd_b];
            o_rd16         <= pair16(i_rd_a);
            o_status_flags <= status_flags;
            o_stack_ptr    <= stack_ptr;
            o_ptr_addr     <= ptr_eff;
            o_ptr_is_reg   <= i_ptr.valid && ptr_eff[15:5] == 11'h000;
            o_irq_accept   <= i_irq_pending && status_flags[csr_pkg::FLAG_I]
                              && !i_irq_enable_clear_op;
            o_prog_valid   <= i_table_op != csr_pkg::TBL_NONE;
            if (i_table_op == csr_pkg::TBL_PLAIN)
            begin
                o_prog_addr <= {1'b0, pair16(csr_pkg::PTR_Z_LOW)};
            end
            else
            begin
                o_prog_addr <= {upper_half_page_bit, pair16(csr_pkg::PTR_Z_LOW)};
            end
            o_io_rdata <= 8'h00;
            if (i_io.re)
            begin
                unique case (i_io.addr)
                    csr_pkg::IO_STATUS_FLAGS:   o_io_rdata <= status_flags;
                    csr_pkg::IO_STACK_PTR_HIGH: o_io_rdata <= stack_ptr[15:8];
                    csr_pkg::IO_STACK_PTR_LOW:  o_io_rdata <= stack_ptr[7:0];
                    csr_pkg::IO_PROGRAM_PAGE:
                        o_io_rdata <= {7'h00, upper_half_page_bit};
                    default: o_io_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Software may write any flag pattern, so only ALU updates are held to the sign rule
    sign_rule_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_alu.valid && i_alu.op != csr_pkg::ALU_MOV && !i_io.we
        |=> status_flags[4] == (status_flags[2] ^ status_flags[3]))
        else $error("sign flag mismatch");
    push_dec_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_stack_op == csr_pkg::STK_PUSH && !i_io.we |=> stack_ptr == $past(stack_ptr) - 16'h0001)
        else $error("push step wrong");
    call_dec_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_stack_op == csr_pkg::STK_CALL && !i_io.we |=> stack_ptr == $past(stack_ptr) - 16'h0002)
        else $error("call step wrong");
    pop_inc_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_stack_op inside {csr_pkg::STK_POP, csr_pkg::STK_SUB_EXIT} && !i_io.we
        |=> stack_ptr == $past(stack_ptr) + 16'h0001)
        else $error("pop step wrong");
    irq_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_irq_taken && !i_io.we |=> !status_flags[7])
        else $error("enable not cleared");
    irq_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !status_flags[7] |=> !o_irq_accept)
        else $error("interrupt accepted while disabled");
    page_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_io.re && i_io.addr == csr_pkg::IO_PROGRAM_PAGE |=> o_io_rdata[7:1] == 7'h00)
        else $error("reserved page bits nonzero");
    plain_tbl_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_table_op == csr_pkg::TBL_PLAIN |=> !o_prog_addr[16])
        else $error("plain read used page");
    zero_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_alu.valid && i_alu.op == csr_pkg::ALU_XOR && !i_io.we
        && i_alu.dst == i_alu.src && !i_alu.use_imm |=> status_flags[1])
        else $error("zero flag missing");
    push_cov: cover property (@(posedge i_core_clk) i_stack_op == csr_pkg::STK_PUSH);
    call_cov: cover property (@(posedge i_core_clk) i_stack_op == csr_pkg::STK_CALL);
    irq_cov: cover property (@(posedge i_core_clk) o_irq_accept);
endmodule
`default_nettype wire

// ---- verif/csr_irq_model.sv ----
// Interrupt sequencing model at the far side of the status block
`timescale 1ns/100ps
`default_nettype none
module csr_irq_model
(
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_accept,
    output logic      o_taken
);
    // Entry pushes the return address and clears the global enable; other flags are left to software
    always_ff @(posedge i_core_clk)
    begin
        o_taken <= i_accept & ~i_rst;
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench for the status, register file and stack block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                   clk = 0;
    logic                   rst = 1;
    csr_pkg::csr_alu_req_t  alu = '0;
    csr_pkg::csr_bit_req_t  bq = '0;
    csr_pkg::csr_io_req_t   io = '0;
    csr_pkg::csr_stack_op_t stk = csr_pkg::STK_NONE;
    logic [2:0]             irq = '0;
    logic [4:0]             ra = 5'h01;
    logic [4:0]             rb = '0;
    logic                   dwe = 0;
    logic [15:0]            dad = '0;
    logic [7:0]             dwd = '0;
    logic [7:0]             rdat, rda, rdb, flags;
    logic [15:0]            sp;
    logic                   acc, taken;
    logic [15:0]            r16, pad;
    logic [16:0]            pga;
    logic                   pir, pgv;
    csr_pkg::csr_ptr_req_t  pq = '0;
    csr_pkg::csr_table_op_t tbl = csr_pkg::TBL_NONE;
    logic                   w16 = 0;
    logic [4:0]             wix = '0;
    logic [15:0]            wd = '0;
    int                     bad_count = 0;
    int                     tests_run = 0;
    always #12.5 clk = ~clk;
    csr_irq_model partner (.i_core_clk(clk), .i_rst(rst), .i_accept(acc), .o_taken(taken));
    csr_core DUT (.i_core_clk(clk), .i_rst(rst), .i_alu(alu), .i_bit(bq), .i_ptr(pq),
        .i_rd_a(ra), .i_rd_b(rb), .i_wr16_en(w16), .i_wr16_idx(wix), .i_wr16_data(wd),
        .i_dmem_we(dwe), .i_dmem_wdata_addr(dad), .i_dmem_wdata(dwd), .i_io(io),
        .i_stack_op(taken ? csr_pkg::STK_CALL : stk), .i_irq_pending(irq[2]),
        .i_irq_taken(taken), .i_irq_enable_set_op(irq[1]), .i_irq_enable_clear_op(irq[0]),
        .i_table_op(tbl), .o_rd_a(rda), .o_rd_b(rdb), .o_rd16(r16), .o_io_rdata(rdat),
        .o_status_flags(flags), .o_stack_ptr(sp), .o_ptr_addr(pad), .o_ptr_is_reg(pir),
        .o_irq_accept(acc), .o_prog_addr(pga), .o_prog_valid(pgv));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic io_op(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        io <= '{w, ~w, a, d};
        @(posedge clk);
        io <= '0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        io_op(1'b0, a, 8'h00);
        #1 chk("io read", {8'h00, e}, {8'h00, rdat});
    endtask
    task automatic alu_op(input csr_pkg::csr_alu_op_t o, input logic [4:0] d, input logic [4:0] s,
        input logic u, input logic [7:0] m);
        @(posedge clk);
        alu <= '{1'b1, o, d, s, u, m};
        @(posedge clk);
        alu <= '0;
    endtask
    task automatic bit_op(input logic [4:0] r, input logic [2:0] b, input logic t);
        @(posedge clk);
        bq <= '{1'b1, r, b, t};
        @(posedge clk);
        bq <= '0;
    endtask
    task automatic stk_op(input csr_pkg::csr_stack_op_t o, input logic [15:0] e);
        @(posedge clk);
        stk <= o;
        @(posedge clk);
        stk <= csr_pkg::STK_NONE;
        cyc(1);
        chk("stack pointer", e, sp);
    endtask
    task automatic irq_op(input logic [2:0] v);
        @(posedge clk);
        irq <= v;
        @(posedge clk);
        irq <= '0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 0;
        cyc(2);
        rd(6'h3f, 8'h00);
        rd(6'h3d, 8'h00);
        io_op(1'b1, 6'h3b, 8'hff);
        rd(6'h3b, 8'h01);
        rd(6'h30, 8'h00);
        io_op(1'b1, 6'h3e, 8'h10);
        io_op(1'b1, 6'h3d, 8'h00);
        rd(6'h3e, 8'h10);
        $display("test registers done");
        stk_op(csr_pkg::STK_PUSH, 16'h0fff);
        stk_op(csr_pkg::STK_CALL, 16'h0ffd);
        stk_op(csr_pkg::STK_POP, 16'h0ffe);
        stk_op(csr_pkg::STK_SUB_EXIT, 16'h0fff);
        $display("test stack done");
        alu_op(csr_pkg::ALU_MOV, 5'd1, 5'd0, 1'b1, 8'h7f);
        alu_op(csr_pkg::ALU_MOV, 5'd2, 5'd0, 1'b1, 8'h01);
        alu_op(csr_pkg::ALU_ADD, 5'd1, 5'd2, 1'b0, 8'h00);
        cyc(1);
        chk("sum", 16'h0080, {8'h00, rda});
        chk("flags", 16'h002c, {8'h00, flags});
        alu_op(csr_pkg::ALU_ADD, 5'd1, 5'd1, 1'b0, 8'h00);
        cyc(1);
        chk("flags", 16'h001b, {8'h00, flags});
        bit_op(5'd2, 3'd0, 1'b1);
        bit_op(5'd3, 3'd5, 1'b0);
        dwe <= 1;
        dad <= 16'h0005;
        dwd <= 8'ha5;
        rb <= 5'd5;
        ra <= 5'd3;
        @(posedge clk);
        dwe <= 0;
        cyc(2);
        chk("bit copy", 16'h0020, {8'h00, rda});
        chk("flags", 16'h005b, {8'h00, flags});
        chk("data space", 16'h00a5, {8'h00, rdb});
        $display("test alu done");
        irq_op(3'b010);
        irq_op(3'b100);
        #1 chk("accept", 16'h0001, {15'h0000, acc});
        cyc(3);
        chk("flags", 16'h005b, {8'h00, flags});
        chk("stack pointer", 16'h0ffd, sp);
        stk_op(csr_pkg::STK_INT_EXIT, 16'h0ffe);
        chk("flags", 16'h00db, {8'h00, flags});
        irq_op(3'b101);
        #1 chk("accept", 16'h0000, {15'h0000, acc});
        cyc(1);
        chk("flags", 16'h005b, {8'h00, flags});
        $display("test interrupt done");
        alu_op(csr_pkg::ALU_XOR, 5'd4, 5'd4, 1'b0, 8'h00);
        cyc(1);
        chk("flags", 16'h0043, {8'h00, flags});
        @(posedge clk);
        w16 <= 1;
        wix <= 5'h1e;
        wd <= 16'h0011;
        ra <= 5'h1e;
        @(posedge clk);
        w16 <= 0;
        pq <= '{1'b1, 2'h2, csr_pkg::PTR_POSTINC, 6'h00};
        tbl <= csr_pkg::TBL_EXT;
        @(posedge clk);
        pq <= '{1'b1, 2'h2, csr_pkg::PTR_PREDEC, 6'h00};
        tbl <= csr_pkg::TBL_PLAIN;
        #1 chk("pair read", 16'h0011, r16);
        chk("pointer", 16'h0011, pad);
        chk("is reg", 16'h0001, {15'h0000, pir});
        chk("prog addr", 16'h0011, pga[15:0]);
        chk("page", 16'h0003, {14'h0000, pga[16], pgv});
        @(posedge clk);
        pq <= '{1'b1, 2'h2, csr_pkg::PTR_DISP, 6'h21};
        tbl <= csr_pkg::TBL_NONE;
        #1 chk("pointer", 16'h0011, pad);
        chk("prog addr", 16'h0012, pga[15:0]);
        chk("page", 16'h0001, {14'h0000, pga[16], pgv});
        @(posedge clk);
        pq <= '0;
        #1 chk("pointer", 16'h0032, pad);
        chk("is reg", 16'h0000, {15'h0000, pir});
        chk("pair read", 16'h0011, r16);
        $display("test pointer done");
        complete_run();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
